// ===== shared/dctom_pkg.sv
// package: timing constants and state codes for the dual channel torque-off monitor
package dctom_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // fault detection window (ms)
  localparam int unsigned FAULT_MIN_MS = 1600;
  localparam int unsigned FAULT_TYP_MS = 2300;
  localparam int unsigned FAULT_MAX_MS = 3000;
  localparam int unsigned FAULT_TYP_CYC = FAULT_TYP_MS * 1000 * CLK_MHZ;
  // response / pulse immunity (us)
  localparam int unsigned RESP_MIN_US = 2000;
  localparam int unsigned RESP_TYP_US = 6000;
  localparam int unsigned RESP_MAX_US = 10000;
  localparam int unsigned RESP_TYP_CYC = RESP_TYP_US * CLK_MHZ;
  localparam int unsigned CNT_W = 28;

  typedef enum logic [3:0] {
    DCTOM_SAFE = 4'h1,
    DCTOM_RUN = 4'h2,
    DCTOM_MISM = 4'h4,
    DCTOM_LOCK = 4'h8
  } dctom_state_t;
endpackage

// ===== shared/dctom_chan_if.sv
// interface: filtered channel levels from the input filter to the monitor core
`timescale 1ns/1ps
interface dctom_chan_if;
  logic chan_a;
  logic chan_b;
  modport filt (output chan_a, output chan_b);
  modport core (input chan_a, input chan_b);
endinterface

// ===== src/dctom_filter.sv
// input filter: synchroniser plus low-going pulse rejection per channel
`timescale 1ns/1ps
module dctom_filter
  import dctom_pkg::*;
#(
  parameter int unsigned RESP_CYC = RESP_TYP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_raw,
  dctom_chan_if.filt chan
);
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] next_sync1;
  logic [1:0] next_sync2;
  logic [1:0] filt;
  logic [1:0] next_filt;
  logic [CNT_W-1:0] lowcnt [2];
  logic [CNT_W-1:0] next_lowcnt [2];

  // -----------------------------------------------------------
  // two-stage synchroniser
  // -----------------------------------------------------------
  always_comb begin
    next_sync1 = i_raw;
    next_sync2 = sync1;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // -----------------------------------------------------------
  // per-channel low-time filter
  // -----------------------------------------------------------
  // a low must last the full response time before it counts; short test
  // pulses vanish. high is passed at once, which only helps re-arming.
  genvar g;
  for (g = 0; g < 2; g++) begin : g_chan
    always_comb begin
      next_lowcnt[g] = '0;
      next_filt[g] = 1'b1;
      if (sync2[g]) begin
        next_lowcnt[g] = '0;
        next_filt[g] = 1'b1;
      end else if (lowcnt[g] >= CNT_W'(RESP_CYC - 1)) begin
        next_lowcnt[g] = lowcnt[g];
        next_filt[g] = 1'b0;
      end else begin
        next_lowcnt[g] = lowcnt[g] + CNT_W'(1);
        next_filt[g] = filt[g];
      end
    end

    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        lowcnt[g] <= '0;
        filt[g] <= 1'b0;
      end else begin
        lowcnt[g] <= next_lowcnt[g];
        filt[g] <= next_filt[g];
      end
    end
  end

  assign chan.chan_a = filt[0];
  assign chan.chan_b = filt[1];

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  // a channel may only fall once its low has lasted the full count
  for (g = 0; g < 2; g++) begin : g_chk
    a_pulse_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst)
      $fell(filt[g]) |-> (lowcnt[g] == CNT_W'(RESP_CYC - 1)))
      else $error("filter dropped a channel before the full low time");
  end
endmodule

// ===== src/dctom_monitor.sv
// top: dual channel torque-off monitor with mismatch fault latch
`timescale 1ns/1ps
module dctom_monitor
  import dctom_pkg::*;
#(
  parameter int unsigned FAULT_CYC = FAULT_TYP_CYC,
  parameter int unsigned RESP_CYC = RESP_TYP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_channel_a_input,
  input wire logic i_channel_b_input,
  input wire logic i_aux_supply_ok,
  input wire logic i_mains_ok,
  input wire logic i_sw_run_req,
  output logic o_power_enable,
  output logic o_start_permit,
  output logic o_trip,
  output logic o_fault_latched,
  output logic o_status_output_on
);
  dctom_chan_if chan ();
  dctom_state_t state;
  dctom_state_t next_state;
  logic [CNT_W-1:0] mcnt;
  logic [CNT_W-1:0] next_mcnt;
  logic [1:0] pwr_sync;
  logic [1:0] next_pwr_sync;
  logic aux_ok;
  logic mains_ok;
  logic both_hi;
  logic both_lo;
  logic mism;

  dctom_filter #(.RESP_CYC(RESP_CYC)) u_filter (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_raw({i_channel_b_input, i_channel_a_input}),
    .chan(chan)
  );

  // -----------------------------------------------------------
  // supply status synchronisers
  // -----------------------------------------------------------
  logic [1:0] ps1;
  logic [1:0] next_ps1;
  // a supply pin may bounce as it ramps; two flops only synchronise it, so a bounce still reaches the outputs
  always_comb begin
    next_ps1 = {i_mains_ok, i_aux_supply_ok};
    next_pwr_sync = ps1;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ps1 <= 2'h0;
      pwr_sync <= 2'h0;
    end else begin
      ps1 <= next_ps1;
      pwr_sync <= next_pwr_sync;
    end
  end

  // logic alive means aux or mains feeds the control electronics
  assign aux_ok = pwr_sync[0];
  assign mains_ok = pwr_sync[1];

  // -----------------------------------------------------------
  // channel decode
  // -----------------------------------------------------------
  assign both_hi = chan.chan_a & chan.chan_b;
  assign both_lo = ~chan.chan_a & ~chan.chan_b;
  assign mism = chan.chan_a ^ chan.chan_b;

  // -----------------------------------------------------------
  // state machine and mismatch timer
  // -----------------------------------------------------------
  // no mode or command input reaches this machine, so the function
  // cannot be switched off; only reset (power-up) leaves the lock state
  always_comb begin
    next_state = state;
    next_mcnt = '0;
    case (state)
      DCTOM_SAFE: begin
        if (both_hi) begin
          next_state = DCTOM_RUN;
        end else if (mism) begin
          next_state = DCTOM_MISM;
        end
      end
      DCTOM_RUN: begin
        if (both_lo) begin
          next_state = DCTOM_SAFE;
        end else if (mism) begin
          next_state = DCTOM_MISM;
        end
      end
      DCTOM_MISM: begin
        if (!mism) begin
          next_state = both_hi ? DCTOM_RUN : DCTOM_SAFE;
        end else if (mcnt >= CNT_W'(FAULT_CYC - 1)) begin
          next_state = DCTOM_LOCK;
        end else begin
          next_mcnt = mcnt + CNT_W'(1);
        end
      end
      DCTOM_LOCK: begin
        next_state = DCTOM_LOCK;
      end
      default: begin
        next_state = DCTOM_SAFE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= DCTOM_SAFE;
      mcnt <= '0;
    end else begin
      state <= next_state;
      mcnt <= next_mcnt;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  logic next_pwr_en;
  logic next_start;
  logic next_trip;
  logic next_flt;
  logic next_stat;
  always_comb begin
    // run only when mains present and both channels high
    next_start = (state == DCTOM_RUN) && mains_ok;
    next_pwr_en = next_start && i_sw_run_req;
    next_trip = (state != DCTOM_RUN);
    next_flt = (state == DCTOM_LOCK);
    // status lives on the aux rail, so mains is not needed
    next_stat = (state == DCTOM_SAFE) && both_lo && (aux_ok || mains_ok);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_power_enable <= 1'b0;
      o_start_permit <= 1'b0;
      o_trip <= 1'b1;
      o_fault_latched <= 1'b0;
      o_status_output_on <= 1'b0;
    end else begin
      o_power_enable <= next_pwr_en;
      o_start_permit <= next_start;
      o_trip <= next_trip;
      o_fault_latched <= next_flt;
      o_status_output_on <= next_stat;
    end
  end

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  sequence s_mism_begin;
    (state == DCTOM_MISM) && (mcnt == '0);
  endsequence

  // the one step into the lock state
  sequence s_lock_entry;
    (state != DCTOM_LOCK) ##1 (state == DCTOM_LOCK);
  endsequence

  a_lock_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == DCTOM_LOCK) |=> (state == DCTOM_LOCK) && !o_status_output_on)
    else $error("fault latch released without power cycle");
  a_lock_from_mism: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_lock_entry |-> $past(mism, 1))
    else $error("fault latched without mismatch");
  a_no_early_fault: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (next_state == DCTOM_LOCK && state == DCTOM_MISM) |-> (mcnt >= CNT_W'(FAULT_CYC - 1)))
    else $error("fault latched before window");
  a_mism_trips: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_mism_begin |=> o_trip && !o_start_permit && !o_status_output_on)
    else $error("mismatch did not trip");
  a_safe_status: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == DCTOM_SAFE && both_lo && aux_ok) |=> o_status_output_on && !o_power_enable)
    else $error("safe state without status on");
  a_run_status_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == DCTOM_RUN) |=> !o_status_output_on && !o_trip)
    else $error("status on while running");
  a_no_power_unpowered: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !mains_ok |=> !o_power_enable && !o_start_permit)
    else $error("power without mains");
  a_timer_restart: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == DCTOM_MISM && !mism) |=> (mcnt == '0) && (state != DCTOM_LOCK))
    else $error("timer not restarted on agreement");
  // motor power only with a standing permit and a software run request
  a_power_gated: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_power_enable |-> o_start_permit && $past(i_sw_run_req, 1))
    else $error("motor power without permit and run request");
  // running is reached only with both filtered channels high
  a_run_entry: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state != DCTOM_RUN) ##1 (state == DCTOM_RUN) |-> $past(both_hi, 1))
    else $error("run entered without both channels high");
  // with no supply at all the status relay stays open
  a_status_unpowered: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(aux_ok || mains_ok) |=> !o_status_output_on)
    else $error("status on without any supply");
endmodule

// ===== bench/dctom_relay_model.sv
// partner model: two safety relay channels, channel b may lag channel a
`timescale 1ns/1ps
module dctom_relay_model (
  input wire logic i_core_clk,
  input wire logic i_want_a,
  input wire logic i_want_b,
  input wire logic [2:0] i_lag_b,
  output logic o_channel_a,
  output logic o_channel_b
);
  // known idle levels so no unknown reaches the pins at time zero
  logic [7:0] hist_b = 8'h00;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  // contacts switch together when i_lag_b is zero; otherwise the b tap models slow relay skew
  always @(posedge i_core_clk) begin
    hist_b <= {hist_b[6:0], i_want_b};
    a_q <= i_want_a;
    b_q <= (i_lag_b == 3'h0) ? i_want_b : hist_b[i_lag_b - 3'h1];
  end
  assign o_channel_a = a_q;
  assign o_channel_b = b_q;
endmodule

// ===== bench/testbench.sv
// testbench: self-checking scenarios for the dual channel torque-off monitor
`timescale 1ns/1ps
module testbench;
  localparam int T_FAULT = 50;
  localparam int T_RESP = 4;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_aux_supply_ok = 1'b1;
  logic i_mains_ok = 1'b1;
  logic i_sw_run_req = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic [2:0] lag_b = 3'h0;
  logic ch_a;
  logic ch_b;
  logic o_power_enable;
  logic o_start_permit;
  logic o_trip;
  logic o_fault_latched;
  logic o_status_output_on;
  int num_errors = 0;
  int total_checks = 0;
  // short counts keep the run small; expectations derive from them
  dctom_monitor #(.FAULT_CYC(T_FAULT), .RESP_CYC(T_RESP)) i_dctom_monitor (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_channel_a_input(ch_a),
    .i_channel_b_input(ch_b), .i_aux_supply_ok(i_aux_supply_ok),
    .i_mains_ok(i_mains_ok), .i_sw_run_req(i_sw_run_req),
    .o_power_enable(o_power_enable), .o_start_permit(o_start_permit), .o_trip(o_trip),
    .o_fault_latched(o_fault_latched), .o_status_output_on(o_status_output_on));
  dctom_relay_model i_dctom_relay_model (.i_core_clk(i_core_clk), .i_want_a(want_a),
    .i_want_b(want_b), .i_lag_b(lag_b), .o_channel_a(ch_a), .o_channel_b(ch_b));
  // 100 MHz clock
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return o_start_permit;
      1: return o_fault_latched;
      default: return o_status_output_on;
    endcase
  endfunction
  // sample just after the edge so registered outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // bounded wait; running out is a mismatch and ends the run
  task automatic wait_lvl(input int w, input logic exp, input int bound);
    for (int k = 0; k < bound; k++) begin
      step(1);
      if (pick(w) === exp) return;
    end
    num_errors++;
    $display("MISMATCH wait %0d expected %b seen %b", w, exp, pick(w));
    wrap_up();
  endtask
  task automatic drive(input logic a, input logic b);
    @(posedge i_core_clk);
    want_a <= a;
    want_b <= b;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    step(1);
    chk("trip", 1'b1, o_trip);
    chk("permit", 1'b0, o_start_permit);
    wait_lvl(2, 1'b1, 10);
    $display("t_reset done");
  endtask
  task automatic t_run();
    @(posedge i_core_clk);
    lag_b <= 3'h3;
    drive(1'b1, 1'b1);
    wait_lvl(0, 1'b1, 20);
    chk("power_idle", 1'b0, o_power_enable);
    chk("trip", 1'b0, o_trip);
    chk("status", 1'b0, o_status_output_on);
    @(posedge i_core_clk);
    i_sw_run_req <= 1'b1;
    step(2);
    chk("power", 1'b1, o_power_enable);
    drive(1'b0, 1'b1);
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    for (int k = 0; k < 12; k++) begin
      step(1);
      chk("pulse_permit", 1'b1, o_start_permit);
    end
    $display("t_run done");
  endtask
  task automatic t_stop();
    drive(1'b0, 1'b0);
    step(3);
    chk("early_permit", 1'b1, o_start_permit);
    wait_lvl(0, 1'b0, T_RESP + 8);
    chk("power", 1'b0, o_power_enable);
    wait_lvl(2, 1'b1, 10);
    chk("trip", 1'b1, o_trip);
    $display("t_stop done");
  endtask
  task automatic t_mism();
    for (int k = 0; k < 2; k++) begin
      drive(1'b1, 1'b1);
      wait_lvl(0, 1'b1, 20);
      drive(1'b0, 1'b1);
      step(T_RESP + 6);
      chk("trip", 1'b1, o_trip);
      chk("status", 1'b0, o_status_output_on);
      chk("permit", 1'b0, o_start_permit);
      step(T_FAULT - 20);
      chk("fault", 1'b0, o_fault_latched);
    end
    $display("t_mism done");
  endtask
  task automatic t_lock();
    drive(1'b1, 1'b1);
    wait_lvl(0, 1'b1, 20);
    drive(1'b0, 1'b1);
    wait_lvl(1, 1'b1, T_FAULT + T_RESP + 20);
    drive(1'b1, 1'b1);
    step(20);
    chk("fault", 1'b1, o_fault_latched);
    chk("permit", 1'b0, o_start_permit);
    drive(1'b0, 1'b0);
    step(20);
    chk("status", 1'b0, o_status_output_on);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    step(1);
    chk("fault", 1'b0, o_fault_latched);
    chk("permit", 1'b0, o_start_permit);
    $display("t_lock done");
  endtask
  task automatic t_supply();
    @(posedge i_core_clk);
    i_mains_ok <= 1'b0;
    wait_lvl(2, 1'b1, 10);
    step(4);
    chk("status_aux", 1'b1, o_status_output_on);
    @(posedge i_core_clk);
    i_aux_supply_ok <= 1'b0;
    wait_lvl(2, 1'b0, 10);
    drive(1'b1, 1'b1);
    step(20);
    chk("permit", 1'b0, o_start_permit);
    chk("power", 1'b0, o_power_enable);
    chk("status", 1'b0, o_status_output_on);
    @(posedge i_core_clk);
    i_mains_ok <= 1'b1;
    i_aux_supply_ok <= 1'b1;
    wait_lvl(0, 1'b1, 20);
    $display("t_supply done");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_reset();
    t_run();
    t_stop();
    t_mism();
    t_lock();
    t_supply();
    wrap_up();
  end
endmodule
